// [hw/acs_top.sv]
// converter control and status logic with an axi4-lite register slave
// How it works
// - converter_on enables the converter; clearing it aborts a running conversion.
// - convert_go starts each single conversion, or the first free running one.
// - first conversion after enable takes 25 converter clocks, later ones 13.
// - convert_go reads one while busy, zero after; writing zero does nothing.
// - with auto trigger on, a rising selected trigger starts a conversion.
// - done flag sets on result update; irq while flag and both enables.
// - vector acknowledge or writing one clears the done flag.
// - either enable low masks the request but keeps the flag.
// - converter clock is system clock divided by 2,2,4,8,16,32,64,128.
// - low byte read freezes the pair until the high byte is read.
// - right alignment by default; left alignment puts bits 9:2 in high byte.
// - bipolar_select picks unipolar or two's complement results.
// - gain_boost_select swaps 20x for 32x and 1x for 8x.
// - bit 5 of converter_control_b reads zero and ignores writes.
// - reference bits choose the 1.1 V or 2.56 V internal reference.
// - channel select changes wait until the running conversion completes.
// - trigger source is ignored while auto trigger is off.
// - switching from a source whose flag is clear to one whose flag is set counts as an edge.
// - switching to free running code 0 never triggers.
// - trigger source codes 1 to 7 map to the seven on-chip event flags.
// - a pin disable bit forces that pin's digital input to zero.
// - refpin disable forces the reference pin's digital input to zero.
// - reference code decodes supply, pin, 1.1V, reserved, 2.56V options.
// - any reference change makes the next conversion 25 cycles long.
// - alignment change re-presents the result immediately.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "acs_cfg.svh"
module acs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire acs_pkg::acs_axil_req_t axi_req,
  output acs_pkg::acs_axil_rsp_t axi_rsp,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  input wire logic [6:0] trigger_flags,
  input wire logic [9:0] analog_result,
  input wire logic [10:0] pin_raw,
  input wire logic refpin_raw,
  output logic core_enable,
  output logic core_start,
  output logic core_busy,
  output logic core_sample,
  output logic core_tick,
  output logic [5:0] core_channel,
  output logic [2:0] core_reference,
  output logic core_bipolar,
  output logic core_gain_boost,
  output logic [10:0] pin_digital,
  output logic refpin_digital,
  output logic conv_irq
);
  acs_pkg::acs_state_t s;
  acs_pkg::acs_state_t next_s;
  logic awready;
  logic wready;
  logic arready;
  logic do_write;
  logic wr_ok;
  logic sel_flag;
  logic trig_edge;
  logic start;
  logic done;
  logic sw_go;
  logic rd_take;
  logic rd_low;
  logic rd_high;
  logic res_written;
  logic [7:0] res_high;
  logic [7:0] res_low;
  logic [11:0] dis_vec;

  // unmapped: index 0, upper bits set, or not word aligned
  function automatic logic addr_bad(input logic [31:0] a);
    addr_bad = (a[31:5] != 27'h0) || (a[1:0] != 2'h0) || (a[4:2] == 3'h0);
  endfunction

  // trigger flag of the chosen source; code 0 has none, so it never edges
  function automatic logic sel_trig(input logic [2:0] tss, input logic [6:0] flags);
    sel_trig = (tss == 3'h0) ? 1'b0 : flags[tss - 3'h1];
  endfunction

  function automatic logic [4:0] conv_last(input logic long_run);
    conv_last = long_run ? (`ACS_CYC_INIT - 5'd1) : (`ACS_CYC_NORM - 5'd1);
  endfunction

  acs_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s.on),
    .div_sel(s.div),
    .tick(core_tick)
  );

  acs_result u_res (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample(done),
    .sample_data(analog_result),
    .left_align(s.left),
    .rd_low(rd_low),
    .rd_high(rd_high),
    .written(res_written),
    .high_byte(res_high),
    .low_byte(res_low)
  );

  // bus handshakes; one write and one read outstanding at a time
  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign arready = !s.rvalid;
  assign do_write = s.aw_held && s.w_held && !s.bvalid;
  assign wr_ok = do_write && !s.aw_bad && s.wstb;
  assign rd_take = axi_req.arvalid && arready;
  assign rd_low = rd_take && !addr_bad(axi_req.araddr) && axi_req.araddr[4:2] == `ACS_IDX_RES_LO;
  assign rd_high = rd_take && !addr_bad(axi_req.araddr) && axi_req.araddr[4:2] == `ACS_IDX_RES_HI;
  assign axi_rsp.awready = awready;
  assign axi_rsp.wready = wready;
  assign axi_rsp.bvalid = s.bvalid;
  assign axi_rsp.bresp = s.bresp;
  assign axi_rsp.arready = arready;
  assign axi_rsp.rvalid = s.rvalid;
  assign axi_rsp.rdata = {24'h000000, s.rdata};
  assign axi_rsp.rresp = s.rresp;

  // pin disables in port order: pins 10..0 then the reference pin on top
  assign dis_vec = {s.didr_a[`ACS_D_REFPIN], s.didr_b, s.didr_a[7:`ACS_D_HIGH], s.didr_a[2:0]};

  // trigger selection tracked even while auto trigger is off; the edge counts only with it on
  assign sel_flag = sel_trig(s.tss, trigger_flags);
  assign trig_edge = s.auto_trig && sel_flag && !s.prev_trig;
  assign done = (s.conv == acs_pkg::conv_busy) && core_tick && (s.cyc == conv_last(s.long_run));
  assign sw_go = wr_ok && (s.aw_idx == `ACS_IDX_CTRL_A) && s.wdata[`ACS_A_GO]
                 && s.wdata[`ACS_A_ON];

  // main next-state process: bus, registers, conversion sequencing, pins
  always_comb begin
    next_s = s;
    start = 1'b0;
    next_s.start_p = 1'b0;
    // two-flop synchroniser, then the disable gate on the second stage
    next_s.pin_s1 = {refpin_raw, pin_raw};
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_val = s.pin_s2 & ~dis_vec;
    if (axi_req.awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx = axi_req.awaddr[4:2];
      next_s.aw_bad = addr_bad(axi_req.awaddr);
    end
    if (axi_req.wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = axi_req.wdata[7:0];
      next_s.wstb = axi_req.wstrb[0];
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = s.aw_bad ? `ACS_RESP_SLVERR : `ACS_RESP_OKAY;
    end
    // register writes; result bytes are read-only and ignore writes
    if (wr_ok) begin
      unique case (s.aw_idx)
        `ACS_IDX_CTRL_A: begin
          next_s.on = s.wdata[`ACS_A_ON];
          next_s.auto_trig = s.wdata[`ACS_A_AUTO];
          next_s.ie = s.wdata[`ACS_A_IE];
          next_s.div = s.wdata[`ACS_A_DIV +: 3];
          if (s.wdata[`ACS_A_FLAG]) begin
            next_s.flag = 1'b0;
          end
        end
        `ACS_IDX_CTRL_B: begin
          next_s.bip = s.wdata[`ACS_B_BIP];
          next_s.gain = s.wdata[`ACS_B_GAIN];
          next_s.ref_hi = s.wdata[`ACS_B_REFHI];
          next_s.ch_msb = s.wdata[`ACS_B_CHMSB];
          next_s.tss = s.wdata[`ACS_B_TSS +: 3];
        end
        `ACS_IDX_CHSEL: begin
          next_s.ref_lo = s.wdata[`ACS_C_REFLO +: 2];
          next_s.left = s.wdata[`ACS_C_LEFT];
          next_s.mux_lo = s.wdata[`ACS_C_MUXLO +: 5];
        end
        `ACS_IDX_DIDR_A: next_s.didr_a = s.wdata;
        `ACS_IDX_DIDR_B: next_s.didr_b = s.wdata[7:`ACS_D_HIGH];
        default: ;
      endcase
    end
    next_s.prev_trig = sel_flag;
    // conversion sequencing; a start while busy is simply not taken
    unique case (s.conv)
      acs_pkg::conv_off: begin
        if (sw_go) begin
          start = 1'b1;
        end else if (next_s.on) begin
          next_s.conv = acs_pkg::conv_idle;
        end
      end
      acs_pkg::conv_idle: begin
        if (sw_go || trig_edge) begin
          start = 1'b1;
        end
      end
      acs_pkg::conv_busy: begin
        if (core_tick) begin
          next_s.cyc = s.cyc + 5'd1;
        end
        if (done) begin
          next_s.conv = acs_pkg::conv_idle;
          // free running restarts straight from completion
          if ((s.auto_trig && s.tss == 3'h0) || trig_edge) begin
            start = 1'b1;
          end
        end
      end
    endcase
    if (start) begin
      next_s.conv = acs_pkg::conv_busy;
      next_s.cyc = 5'd0;
      next_s.long_run = s.need_long;
      next_s.need_long = 1'b0;
      next_s.start_p = 1'b1;
    end
    if ({next_s.ref_hi, next_s.ref_lo} != {s.ref_hi, s.ref_lo}) begin
      next_s.need_long = 1'b1;
    end
    // switching off aborts, and arms the initialisation run for later
    if (!next_s.on) begin
      next_s.conv = acs_pkg::conv_off;
      next_s.cyc = 5'd0;
      // a trigger landing on the switch-off write must not pulse the core
      next_s.start_p = 1'b0;
      next_s.need_long = 1'b1;
    end
    // channel and reference stay frozen for the running conversion
    if (s.conv != acs_pkg::conv_busy || done) begin
      next_s.eff_mux = {next_s.ch_msb, next_s.mux_lo};
      next_s.eff_ref = {next_s.ref_hi, next_s.ref_lo};
    end
    if (irq_ack) begin
      next_s.flag = 1'b0;
    end
    // completion beats a same-cycle clear so no event is lost
    if (res_written) begin
      next_s.flag = 1'b1;
    end
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = addr_bad(axi_req.araddr) ? `ACS_RESP_SLVERR : `ACS_RESP_OKAY;
      next_s.rdata = `ACS_RST_BYTE;
      if (!addr_bad(axi_req.araddr)) begin
        unique case (axi_req.araddr[4:2])
          `ACS_IDX_CTRL_A: next_s.rdata = {s.on, s.conv == acs_pkg::conv_busy,
                                           s.auto_trig, s.flag, s.ie, s.div};
          `ACS_IDX_CTRL_B: next_s.rdata = {s.bip, s.gain, 1'b0, s.ref_hi,
                                           s.ch_msb, s.tss};
          `ACS_IDX_CHSEL: next_s.rdata = {s.ref_lo, s.left, s.mux_lo};
          `ACS_IDX_RES_LO: next_s.rdata = res_low;
          `ACS_IDX_RES_HI: next_s.rdata = res_high;
          `ACS_IDX_DIDR_A: next_s.rdata = s.didr_a;
          `ACS_IDX_DIDR_B: next_s.rdata = {s.didr_b, 4'h0};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs toward the analog core and the pins
  assign core_enable = s.on;
  assign core_start = s.start_p;
  assign core_busy = (s.conv == acs_pkg::conv_busy);
  assign core_sample = done;
  assign core_channel = s.eff_mux;
  assign core_reference = s.eff_ref;
  assign core_bipolar = s.bip;
  assign core_gain_boost = s.gain;
  assign pin_digital = s.pin_val[10:0];
  assign refpin_digital = s.pin_val[11];
  assign conv_irq = s.flag && s.ie && global_irq_enable;

  // helper: converter clocks seen since the conversion started
  logic [4:0] chk_ticks;
  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      chk_ticks <= 5'd0;
    end else if (core_busy && core_tick) begin
      chk_ticks <= chk_ticks + 5'd1;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence trig_rise;
    s.conv == acs_pkg::conv_idle && s.auto_trig && sel_flag && !s.prev_trig && !do_write;
  endsequence
  sequence quiet_zero_source;
    s.conv == acs_pkg::conv_idle && s.tss == 3'h0 && !do_write;
  endsequence

  a_off_aborts: assert property (!s.on |-> s.conv == acs_pkg::conv_off && !core_busy)
    else $error("converter busy while switched off");
  a_conv_length: assert property (done |-> chk_ticks == conv_last(s.long_run))
    else $error("conversion length wrong");
  a_init_after_on: assert property ($rose(s.on) ##0 (s.conv != acs_pkg::conv_busy) [*1] ##1
    start |=> s.long_run)
    else $error("first conversion after enable not long");
  a_trig_starts: assert property (trig_rise |=> core_busy && core_start)
    else $error("trigger edge did not start a conversion");
  a_zero_no_trig: assert property (quiet_zero_source |=> !core_start)
    else $error("free running code produced a trigger");
  a_flag_sets: assert property (res_written |=> s.flag)
    else $error("done flag not set on result update");
  a_flag_acks: assert property (irq_ack && !res_written |=> !s.flag)
    else $error("acknowledge did not clear done flag");
  a_mask_keeps: assert property (s.flag && !irq_ack && !wr_ok ##1 !s.ie |-> s.flag && !conv_irq)
    else $error("masking lost the flag or leaked the request");
  a_chan_hold: assert property (core_busy && !done |=> $stable(core_channel))
    else $error("channel changed during conversion");
  a_pin_gate: assert property (##1 (pin_digital & $past(dis_vec[10:0])) == 11'h000)
    else $error("disabled pin reads non-zero");
  a_busy_start: assert property (core_start |-> core_busy ##1 (core_busy || !s.on || done) [*1])
    else $error("start without busy");
endmodule

// [hw/acs_cfg.svh]
// register indices, field positions, reset values and cycle counts of the converter control block
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// register indices; byte address is four times the index
`define ACS_IDX_DIDR_A 3'h1
`define ACS_IDX_DIDR_B 3'h2
`define ACS_IDX_CTRL_B 3'h3
`define ACS_IDX_RES_LO 3'h4
`define ACS_IDX_RES_HI 3'h5
`define ACS_IDX_CTRL_A 3'h6
`define ACS_IDX_CHSEL 3'h7
// converter_control_a fields
`define ACS_A_ON 7
`define ACS_A_GO 6
`define ACS_A_AUTO 5
`define ACS_A_FLAG 4
`define ACS_A_IE 3
`define ACS_A_DIV 0
// converter_control_b fields
`define ACS_B_BIP 7
`define ACS_B_GAIN 6
`define ACS_B_REFHI 4
`define ACS_B_CHMSB 3
`define ACS_B_TSS 0
// channel select register fields
`define ACS_C_REFLO 6
`define ACS_C_LEFT 5
`define ACS_C_MUXLO 0
// digital input disable fields
`define ACS_D_HIGH 4
`define ACS_D_REFPIN 3
// reset value of every register byte
`define ACS_RST_BYTE 8'h00
// conversion lengths in converter clock cycles
`define ACS_CYC_INIT 5'd25
`define ACS_CYC_NORM 5'd13
// axi responses
`define ACS_RESP_OKAY 2'b00
`define ACS_RESP_SLVERR 2'b10
`endif

// [hw/acs_pkg.sv]
// types and shared functions of the converter control block
package acs_pkg;
  typedef enum logic [1:0] {
    conv_off = 2'b00,
    conv_idle = 2'b01,
    conv_busy = 2'b11
  } acs_conv_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } acs_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acs_axil_rsp_t;

  typedef struct packed {
    acs_conv_t conv;
    logic on;
    logic auto_trig;
    logic flag;
    logic ie;
    logic [2:0] div;
    logic bip;
    logic gain;
    logic ref_hi;
    logic ch_msb;
    logic [2:0] tss;
    logic [1:0] ref_lo;
    logic left;
    logic [4:0] mux_lo;
    logic [7:0] didr_a;
    logic [3:0] didr_b;
    logic [5:0] eff_mux;
    logic [2:0] eff_ref;
    logic need_long;
    logic long_run;
    logic [4:0] cyc;
    logic prev_trig;
    logic start_p;
    logic aw_held;
    logic aw_bad;
    logic [2:0] aw_idx;
    logic w_held;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic [11:0] pin_val;
  } acs_state_t;

  typedef struct packed {
    logic [9:0] result;
    logic lock;
  } acs_res_state_t;

  typedef struct packed {
    logic [6:0] cnt;
  } acs_pre_state_t;

  // division factor of the converter clock
  function automatic logic [7:0] div_of(input logic [2:0] sel);
    div_of = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
  endfunction
endpackage

// [hw/acs_prescaler.sv]
// converter clock prescaler producing one tick per converter clock period
module acs_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);
  acs_pkg::acs_pre_state_t s;
  acs_pkg::acs_pre_state_t next_s;

  // compare with >= so a smaller divisor picked mid-count cannot overshoot
  assign tick = run && ({1'b0, s.cnt} >= (acs_pkg::div_of(div_sel) - 8'h01));

  always_comb begin
    next_s = s;
    if (!run || tick) begin
      next_s.cnt = 7'h00;
    end else begin
      next_s.cnt = s.cnt + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // helper: cycles since last tick, valid only over an undisturbed period
  logic [7:0] chk_gap;
  logic chk_clean;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_gap <= 8'h00;
      chk_clean <= 1'b0;
    end else begin
      chk_gap <= tick ? 8'h00 : chk_gap + 8'h01;
      chk_clean <= (tick || chk_clean) && run && !$changed(div_sel);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tick_period: assert property (tick && chk_clean && $stable(div_sel) |->
    chk_gap == acs_pkg::div_of(div_sel) - 8'h01)
    else $error("converter clock period does not match divider");
endmodule

// [hw/acs_result.sv]
// result register pair with low-then-high read lock and alignment
module acs_result (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample,
  input wire logic [9:0] sample_data,
  input wire logic left_align,
  input wire logic rd_low,
  input wire logic rd_high,
  output logic written,
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);
  acs_pkg::acs_res_state_t s;
  acs_pkg::acs_res_state_t next_s;

  // a result arriving while locked is dropped so the pair stays coherent
  // a low read in the same cycle already returned the old byte, so drop then too
  assign written = sample && !s.lock && !rd_low;

  // alignment is applied on the way out, so a change shows at once
  assign high_byte = left_align ? s.result[9:2] : {6'h00, s.result[9:8]};
  assign low_byte = left_align ? {s.result[1:0], 6'h00} : s.result[7:0];

  always_comb begin
    next_s = s;
    if (rd_low) begin
      next_s.lock = 1'b1;
    end
    if (rd_high) begin
      next_s.lock = 1'b0;
    end
    if (written) begin
      next_s.result = sample_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lock_holds: assert property (s.lock && !rd_high ##1 sample |=> $stable(s.result))
    else $error("locked result was overwritten");
  a_lock_release: assert property (rd_low ##1 (!rd_high && !rd_low) [*2] |-> s.lock)
    else $error("lock dropped without high byte read");
  a_high_unlocks: assert property (rd_high && !rd_low |=> !s.lock)
    else $error("high byte read did not release lock");
endmodule

// [sim/acs_core_model.sv]
// analog core stand-in returning a code built from the frozen channel and reference and the live polarity
module acs_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_enable,
  input wire logic core_sample,
  input wire logic [5:0] core_channel,
  input wire logic [2:0] core_reference,
  input wire logic core_bipolar,
  output logic [9:0] analog_result
);
  logic [9:0] noise;
  // toggling pattern outside the sample cycle, so a mistimed capture shows up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      noise <= 10'h2aa;
    end else begin
      noise <= ~noise;
    end
  end
  // code carries channel, reference and polarity, so stale selections are visible
  assign analog_result = (core_sample && core_enable) ?
    {core_channel, core_reference, core_bipolar} : noise;
endmodule

// [sim/acs_top_tb.sv]
// self-checking bench of the converter control block
module acs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, global_irq_enable, irq_ack, refpin_raw;
  logic [6:0] trigger_flags;
  logic [9:0] analog_result;
  logic [10:0] pin_raw, pin_digital;
  logic core_enable, core_start, core_busy, core_sample, core_tick;
  logic [5:0] core_channel;
  logic [2:0] core_reference;
  logic core_bipolar, core_gain_boost, refpin_digital, conv_irq;
  acs_pkg::acs_axil_req_t axi_req;
  acs_pkg::acs_axil_rsp_t axi_rsp;
  int mismatches, num_checks, ticks, last_ticks, dones, gap, last_gap, n0, starts;
  logic [31:0] d;
  logic [1:0] r;

  acs_top u_acs_top (.aclk, .aresetn, .axi_req, .axi_rsp, .global_irq_enable, .irq_ack,
    .trigger_flags, .analog_result, .pin_raw, .refpin_raw, .core_enable, .core_start,
    .core_busy, .core_sample, .core_tick, .core_channel, .core_reference, .core_bipolar,
    .core_gain_boost, .pin_digital, .refpin_digital, .conv_irq);
  acs_core_model u_acs_core_model (.aclk, .aresetn, .core_enable, .core_sample,
    .core_channel, .core_reference, .core_bipolar, .analog_result);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // tick spacing and busy tick count, sampled mid-cycle once outputs settle
  always @(negedge aclk) begin
    if (core_tick) begin
      last_gap = gap;
      gap = 1;
    end else gap++;
    if (!core_busy) ticks = 0;
    else if (core_tick) ticks++;
    if (core_start) starts++;
    if (core_sample) begin
      last_ticks = ticks;
      dones++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic hang;
    mismatches++;
    conclude();
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    int t;
    t = 0;
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= v;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid && t < 50);
    if (t >= 50) hang();
    chk(32'(axi_rsp.bresp), 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rr);
    int t;
    t = 0;
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid && t < 50);
    if (t >= 50) hang();
    v = axi_rsp.rdata;
    rr = axi_rsp.rresp;
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rr;
    rd(a, v, rr);
    chk(v, exp);
  endtask

  task automatic wait_done(input int n);
    int t;
    t = 0;
    while (dones == n && t < 5000) begin
      @(negedge aclk);
      t++;
    end
    if (t >= 5000) hang();
  endtask

  // start through control a, then compare the converter clocks spent busy
  task automatic run(input logic [31:0] ca, input int n);
    int s;
    s = dones;
    wr(32'h18, ca);
    wait_done(s);
    chk(last_ticks, n);
  endtask

  task automatic idle_chk;
    n0 = dones;
    repeat (120) @(negedge aclk);
    chk(dones, n0);
  endtask

  initial begin
    axi_req = '0;
    axi_req.bready = 1'b1;
    axi_req.wstrb = 4'hf;
    axi_req.rready = 1'b1;
    {aresetn, global_irq_enable, irq_ack, trigger_flags} = '0;
    pin_raw = 11'h7ff;
    refpin_raw = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped slot, reserved bit, control outputs
    for (int i = 1; i < 8; i++) rc(32'(4 * i), 32'h0);
    rd(32'h0, d, r);
    chk(32'(r), 32'h2);
    wr(32'h0c, 32'hff);
    rc(32'h0c, 32'hdf);
    @(negedge aclk);
    chk({core_gain_boost, core_bipolar}, 2'b11);
    // digital input disables
    wr(32'h04, 32'h08);
    repeat (4) @(negedge aclk);
    chk({refpin_digital, pin_digital}, 12'h7ff);
    wr(32'h04, 32'hf7);
    wr(32'h08, 32'hf0);
    repeat (4) @(negedge aclk);
    chk({refpin_digital, pin_digital}, 12'h800);
    // every prescaler code
    for (int c = 0; c < 8; c++) begin
      wr(32'h18, 32'h80 | c);
      repeat (3 * (c == 0 ? 2 : 1 << c)) @(negedge aclk);
      chk(last_gap, c == 0 ? 2 : 1 << c);
    end
    chk(core_enable, 1'b1);
    // long then normal conversion, alignment, flag and interrupt gating
    wr(32'h0c, 32'h88);
    wr(32'h1c, 32'h05);
    run(32'hc0, 25);
    run(32'hc0, 13);
    rc(32'h18, 32'h90);
    rc(32'h10, 32'h51);
    rc(32'h14, 32'h02);
    wr(32'h1c, 32'h25);
    rc(32'h10, 32'h40);
    rc(32'h14, 32'h94);
    wr(32'h18, 32'h88);
    @(negedge aclk);
    chk(conv_irq, 1'b0);
    @(posedge aclk);
    global_irq_enable <= 1'b1;
    @(negedge aclk);
    chk(conv_irq, 1'b1);
    @(posedge aclk);
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    @(negedge aclk);
    chk(conv_irq, 1'b0);
    rc(32'h18, 32'h88);
    // busy readback and channel change held off until completion
    n0 = dones;
    wr(32'h18, 32'hc8);
    rc(32'h18, 32'hc8);
    wr(32'h1c, 32'h23);
    @(negedge aclk);
    chk(core_channel, 6'h25);
    wait_done(n0);
    @(negedge aclk);
    chk(core_channel, 6'h23);
    rc(32'h18, 32'h98);
    wr(32'h18, 32'h98);
    rc(32'h18, 32'h88);
    // low-byte read holds the pair through a completed conversion
    rc(32'h10, 32'h40);
    n0 = dones;
    wr(32'h18, 32'hc8);
    wait_done(n0);
    rc(32'h18, 32'h88);
    rc(32'h14, 32'h94);
    run(32'hc8, 13);
    rc(32'h10, 32'h40);
    rc(32'h14, 32'h8c);
    // abort by switching off, restart with enable and start together
    wr(32'h18, 32'hc8);
    wr(32'h18, 32'h10);
    @(negedge aclk);
    chk({core_busy, core_enable}, 2'b00);
    rc(32'h18, 32'h00);
    run(32'hc0, 25);
    wr(32'h1c, 32'h63);
    run(32'hc0, 25);
    rc(32'h10, 32'hc0);
    rc(32'h14, 32'h8c);
    // auto trigger: ignored while off, then every flag source code 1 to 7
    wr(32'h0c, 32'h89);
    @(posedge aclk);
    trigger_flags <= 7'h01;
    idle_chk();
    @(posedge aclk);
    trigger_flags <= 7'h00;
    wr(32'h18, 32'ha0);
    for (int k = 1; k < 8; k++) begin
      wr(32'h0c, 32'h88 | k);
      n0 = dones;
      @(posedge aclk);
      trigger_flags <= 7'(1 << (k - 1));
      wait_done(n0);
      chk(last_ticks, 13);
      @(posedge aclk);
      trigger_flags <= 7'h00;
    end
    // source switch edges and free running
    wr(32'h0c, 32'h89);
    @(posedge aclk);
    trigger_flags <= 7'h02;
    idle_chk();
    n0 = dones;
    wr(32'h0c, 32'h8a);
    wait_done(n0);
    wr(32'h0c, 32'h88);
    idle_chk();
    n0 = dones;
    wr(32'h18, 32'he0);
    wait_done(n0);
    wait_done(n0 + 1);
    wait_done(n0 + 2);
    wr(32'h18, 32'h80);
    repeat (100) @(negedge aclk);
    idle_chk();
    chk(starts, dones + 1);
    conclude();
  end

  initial begin
    repeat (60000) @(posedge aclk);
    hang();
  end
endmodule
